// ===== mpf_pkg.sv
package mpf_pkg;
   // -----------------------------------------------------------------
   // System control word bit positions
   // -----------------------------------------------------------------
   localparam int SC_EXT_INTERRUPT_ZERO_BIT = 16;
   localparam int SC_EXT_INTERRUPT_ONE_BIT = 17;
   localparam int SC_EXT_INTERRUPT_TWO_BIT = 18;
   localparam int SC_TMX_BIT = 19;
   localparam int SC_GPIO_BIT = 20;
   localparam logic [31:0] SC_RESET = 32'h0000_0000;

   localparam int BUS_W = 16;
   localparam int ADDR_W = 24;
   localparam int NFLAG = 4;
   localparam logic [BUS_W-1:0] BUS_ZERO = 16'h0000;
   localparam logic [BUS_W-1:0] BUS_ONES = 16'hffff;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h00_0000;
   localparam logic [NFLAG-1:0] FLAG_ZERO = 4'h0;
   localparam logic [NFLAG-1:0] FLAG_ONES = 4'hf;

   // Access request from the core or DMA
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [BUS_W-1:0] wdata;
   } mpf_req_t;

   typedef enum logic [3:0] {
      MPF_IDLE = 4'b0001,
      MPF_ADDR = 4'b0010,
      MPF_DATA = 4'b0100,
      MPF_DONE = 4'b1000
   } mpf_state_t;
endpackage

// ===== mpf_port.sv
// What this block does
// R1: Addresses and data share the sixteen bus pins, the latch strobe marking the address phase.
// R2: A configuration input selects byte-wide or halfword-wide bus mode.
// R3: In byte mode the latch strobe pulses when the upper sixteen address bits change.
// R4: In halfword mode the latch strobe pulses when the low sixteen address bits change.
// R5: System control bit 20 with the port disabled makes the bus pins sixteen flags.
// R6: The read strobe is low during each external read and high otherwise.
// R7: The write strobe is low during each external write and high otherwise.
// R8: In flag mode all three bus strobes stay deasserted.
// R9: The latch strobe marks a new address, active high after reset, software may invert it.
// R10: Each dedicated flag pin is an input, testable, or a driven output.
// R11: Flags can act as serial slave selects; flag zero selects the boot memory in master boot.
// R12: System control bits 16 to 18 turn flags zero to two into interrupt inputs.
// R13: System control bit 19 turns flag three into the timer expiry output.
// R14: With the bus pins as inputs, the first input data channel takes parallel data from them.
// R15: After reset bus pins float, read and write strobes high, latch strobe low, flags float.
// R16: An access whose address needs a new latch shows its address phase with the latch strobe before its data phase; others go straight to data.
//
// The strobed register port and the address map were left to the implementer.
module mpf_port
   import mpf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [31:0] system_control_word,
   input wire logic port_enable,
   input wire logic mode_16bit,
   input wire logic ale_active_low,
   input wire logic req_valid,
   input wire mpf_req_t req,
   output logic req_ready,
   output logic rd_valid,
   output logic [BUS_W-1:0] rd_data,
   input wire logic [BUS_W-1:0] shared_addr_data_pins_in,
   output logic [BUS_W-1:0] shared_addr_data_pins_out,
   output logic [BUS_W-1:0] shared_addr_data_pins_oe_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic latch_strobe,
   input wire logic [BUS_W-1:0] bus_pins_as_gpio_out,
   input wire logic [BUS_W-1:0] bus_pins_as_gpio_dir,
   output logic [BUS_W-1:0] bus_pins_as_gpio_in,
   input wire logic idp_capture,
   output logic input_data_port_valid,
   output logic [BUS_W-1:0] input_data_port_data,
   input wire logic [NFLAG-1:0] dedicated_gp_pins_in,
   output logic [NFLAG-1:0] dedicated_gp_pins_out,
   output logic [NFLAG-1:0] dedicated_gp_pins_oe_n,
   input wire logic [NFLAG-1:0] flag_out_value,
   input wire logic [NFLAG-1:0] flag_dir_out,
   output logic [NFLAG-1:0] flag_test,
   input wire logic spi_master,
   input wire logic [NFLAG-1:0] spi_select_n,
   input wire logic spi_boot,
   input wire logic boot_select_n,
   input wire logic timer_expired,
   output logic ext_interrupt_zero,
   output logic ext_interrupt_one,
   output logic ext_interrupt_two
);
   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // Two flops cost latency: flag tests and read data lag the pins
   logic [BUS_W-1:0] bus_s1, bus_s2;
   logic [NFLAG-1:0] flg_s1, flg_s2;
   logic [BUS_W-1:0] next_bus_s1, next_bus_s2;
   logic [NFLAG-1:0] next_flg_s1, next_flg_s2;

   always_comb begin
      next_bus_s1 = shared_addr_data_pins_in;
      next_bus_s2 = bus_s1;
      next_flg_s1 = dedicated_gp_pins_in;
      next_flg_s2 = flg_s1;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_s1 <= BUS_ONES;
         bus_s2 <= BUS_ONES;
         flg_s1 <= FLAG_ONES;
         flg_s2 <= FLAG_ONES;
      end else if (ce) begin
         bus_s1 <= next_bus_s1;
         bus_s2 <= next_bus_s2;
         flg_s1 <= next_flg_s1;
         flg_s2 <= next_flg_s2;
      end
   end

   // -----------------------------------------------------------------
   // Parallel port access sequencer
   // -----------------------------------------------------------------
   logic gpio_mode;
   assign gpio_mode = system_control_word[SC_GPIO_BIT] & ~port_enable; // R5

   mpf_state_t state, next_state;
   mpf_req_t cur, next_cur;
   logic [ADDR_W-1:0] last_addr, next_last_addr;
   logic addr_known, next_addr_known;
   logic [BUS_W-1:0] ad_out, next_ad_out;
   logic [BUS_W-1:0] ad_oe_n, next_ad_oe_n;
   logic rd_n, next_rd_n, wr_n, next_wr_n, ale_on, next_ale_on;
   logic rdv, next_rdv;
   logic [BUS_W-1:0] rdd, next_rdd;
   logic need_ale;
   // Marks read data on its way through the two pin flip-flops
   logic [1:0] rd_sync, next_rd_sync;
   logic [BUS_W-1:0] rd_oe_n;

   // Byte mode compares the externally latched upper bits, halfword the low
   always_comb begin
      if (mode_16bit) begin
         need_ale = !addr_known ||
                    (req.addr[BUS_W-1:0] != last_addr[BUS_W-1:0]); // R4
      end else begin
         need_ale = !addr_known ||
                    (req.addr[ADDR_W-1:8] != last_addr[ADDR_W-1:8]); // R3
      end
   end

   // Byte reads still drive the low address byte on the upper lanes
   always_comb begin
      rd_oe_n = mode_16bit ? BUS_ONES
                           : {BUS_ZERO[BUS_W-1:8], BUS_ONES[7:0]}; // R1
   end

   always_comb begin
      next_state = state;
      next_cur = cur;
      next_last_addr = last_addr;
      next_addr_known = addr_known;
      next_ad_out = ad_out;
      next_ad_oe_n = ad_oe_n;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      next_ale_on = 1'b0;
      next_rdv = 1'b0;
      next_rdd = rdd;
      next_rd_sync = 2'h0;
      case (state)
         MPF_IDLE: begin
            next_ad_oe_n = BUS_ONES;
            // Requests are ignored while disabled or in flag mode
            if (req_valid && port_enable && !gpio_mode) begin
               next_cur = req;
               if (need_ale) begin
                  next_state = MPF_ADDR;
                  next_ale_on = 1'b1; // R9
                  next_ad_oe_n = BUS_ZERO; // R1
                  next_ad_out = mode_16bit ? req.addr[BUS_W-1:0]
                                           : req.addr[ADDR_W-1:8];
                  next_last_addr = req.addr;
                  next_addr_known = 1'b1;
               end else begin
                  // Address already held by the latch, go straight to data
                  next_state = MPF_DATA;
                  next_rd_n = req.wr;
                  next_wr_n = ~req.wr;
                  next_ad_oe_n = req.wr ? BUS_ZERO : rd_oe_n;
                  next_ad_out = mode_16bit ? req.wdata
                                           : {req.addr[7:0], req.wdata[7:0]};
               end
            end
         end
         MPF_ADDR: begin
            // Data only after the latch strobe has closed
            next_state = MPF_DATA; // R16
            next_rd_n = cur.wr; // R6
            next_wr_n = ~cur.wr; // R7
            next_ad_oe_n = cur.wr ? BUS_ZERO : rd_oe_n;
            // In byte mode low address byte rides the upper lanes
            next_ad_out = mode_16bit ? cur.wdata
                                     : {cur.addr[7:0], cur.wdata[7:0]};
         end
         MPF_DATA: begin
            // Pins sampled under the strobe reach bus_s2 two cycles later
            if (cur.wr) begin
               next_state = MPF_DONE;
            end else if (rd_sync[1]) begin
               next_state = MPF_DONE;
               next_rdv = 1'b1;
               next_rdd = mode_16bit ? bus_s2 // R2
                                     : {BUS_ZERO[BUS_W-1:8], bus_s2[7:0]};
            end else begin
               next_rd_sync = {rd_sync[0], 1'b1}; // R16
            end
         end
         MPF_DONE: begin
            // Release the bus in the same cycle that ready returns
            next_state = MPF_IDLE;
            next_ad_oe_n = BUS_ONES;
         end
         default: next_state = MPF_IDLE;
      endcase
      if (gpio_mode) begin
         // Flag mode overrides the pins, strobes and addr_known whatever the sequencer planned
         next_addr_known = 1'b0;
         next_ad_out = bus_pins_as_gpio_out;
         next_ad_oe_n = ~bus_pins_as_gpio_dir; // R5
         next_rd_n = 1'b1; // R8
         next_wr_n = 1'b1; // R8
         next_ale_on = 1'b0; // R8
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= MPF_IDLE;
         cur <= '0;
         last_addr <= ADDR_ZERO;
         addr_known <= 1'b0;
         ad_out <= BUS_ZERO;
         ad_oe_n <= BUS_ONES; // R15
         rd_n <= 1'b1; // R15
         wr_n <= 1'b1; // R15
         ale_on <= 1'b0;
         rdv <= 1'b0;
         rdd <= BUS_ZERO;
         rd_sync <= 2'h0;
      end else if (ce) begin
         state <= next_state;
         cur <= next_cur;
         last_addr <= next_last_addr;
         addr_known <= next_addr_known;
         ad_out <= next_ad_out;
         ad_oe_n <= next_ad_oe_n;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
         ale_on <= next_ale_on;
         rdv <= next_rdv;
         rdd <= next_rdd;
         rd_sync <= next_rd_sync;
      end
   end

   // -----------------------------------------------------------------
   // Latch strobe polarity, input data port and flag pins
   // -----------------------------------------------------------------
   // Polarity is registered with the strobe so the pin stays a flop output;
   // at reset the pin sits low, which is the inactive level of active high
   logic ale_pin, next_ale_pin;
   logic idv, next_idv;
   logic [BUS_W-1:0] idd, next_idd, gin, next_gin;
   logic [NFLAG-1:0] fl_out, next_fl_out, fl_oe_n, next_fl_oe_n;
   logic [NFLAG-1:0] ftest, next_ftest;
   logic [2:0] irq, next_irq;
   logic [NFLAG-1:0] flag_is_out;
   logic [NFLAG-1:0] flag_val;

   always_comb begin
      next_ale_pin = next_ale_on ^ ale_active_low; // R9
      next_gin = bus_s2;
      next_idv = 1'b0;
      next_idd = idd;
      if (idp_capture && (gpio_mode || (!port_enable))) begin
         next_idv = 1'b1; // R14
         next_idd = bus_s2;
      end
      flag_val = flag_out_value;
      flag_is_out = flag_dir_out; // R10
      if (spi_master) begin
         flag_val = spi_select_n; // R11
         flag_is_out = FLAG_ONES;
      end
      if (spi_boot) begin
         flag_val[0] = boot_select_n; // R11
         flag_is_out[0] = 1'b1;
      end
      if (system_control_word[SC_EXT_INTERRUPT_ZERO_BIT]) flag_is_out[0] = 1'b0; // R12
      if (system_control_word[SC_EXT_INTERRUPT_ONE_BIT]) flag_is_out[1] = 1'b0; // R12
      if (system_control_word[SC_EXT_INTERRUPT_TWO_BIT]) flag_is_out[2] = 1'b0; // R12
      if (system_control_word[SC_TMX_BIT]) begin
         flag_val[3] = timer_expired; // R13
         flag_is_out[3] = 1'b1;
      end
      next_fl_out = flag_val;
      next_fl_oe_n = ~flag_is_out;
      next_ftest = flg_s2; // R10
      next_irq[0] = system_control_word[SC_EXT_INTERRUPT_ZERO_BIT] & ~flg_s2[0]; // R12
      next_irq[1] = system_control_word[SC_EXT_INTERRUPT_ONE_BIT] & ~flg_s2[1];
      next_irq[2] = system_control_word[SC_EXT_INTERRUPT_TWO_BIT] & ~flg_s2[2];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ale_pin <= 1'b0; // R15
         gin <= BUS_ONES;
         idv <= 1'b0;
         idd <= BUS_ZERO;
         fl_out <= FLAG_ZERO;
         fl_oe_n <= FLAG_ONES; // R15
         ftest <= FLAG_ONES;
         irq <= 3'h0;
      end else if (ce) begin
         ale_pin <= next_ale_pin;
         gin <= next_gin;
         idv <= next_idv;
         idd <= next_idd;
         fl_out <= next_fl_out;
         fl_oe_n <= next_fl_oe_n;
         ftest <= next_ftest;
         irq <= next_irq;
      end
   end

   // -----------------------------------------------------------------
   // Request handshake
   // -----------------------------------------------------------------
   // Ready is derived from flops: idle state, enabled, not in flag mode
   logic rdy, next_rdy;
   always_comb begin
      next_rdy = (next_state == MPF_IDLE) && port_enable && !gpio_mode;
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdy <= 1'b0;
      end else if (ce) begin
         rdy <= next_rdy;
      end
   end

   // -----------------------------------------------------------------
   // Pin and status outputs
   // -----------------------------------------------------------------
   assign req_ready = rdy;
   assign rd_valid = rdv;
   assign rd_data = rdd;
   assign shared_addr_data_pins_out = ad_out;
   assign shared_addr_data_pins_oe_n = ad_oe_n;
   assign read_strobe_n = rd_n;
   assign write_strobe_n = wr_n;
   assign latch_strobe = ale_pin;
   assign bus_pins_as_gpio_in = gin;
   assign input_data_port_valid = idv;
   assign input_data_port_data = idd;
   assign dedicated_gp_pins_out = fl_out;
   assign dedicated_gp_pins_oe_n = fl_oe_n;
   assign flag_test = ftest;
   assign ext_interrupt_zero = irq[0];
   assign ext_interrupt_one = irq[1];
   assign ext_interrupt_two = irq[2];
endmodule

// ===== mpf_port_checker.sv
module mpf_port_checker
   import mpf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [31:0] system_control_word,
   input wire logic port_enable,
   input wire logic mode_16bit,
   input wire logic ale_active_low,
   input wire logic req_valid,
   input wire mpf_req_t req,
   input wire logic req_ready,
   input wire logic rd_valid,
   input wire logic [BUS_W-1:0] shared_addr_data_pins_out,
   input wire logic [BUS_W-1:0] shared_addr_data_pins_oe_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic latch_strobe,
   input wire logic [NFLAG-1:0] dedicated_gp_pins_oe_n
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   wire gpio_mode = system_control_word[SC_GPIO_BIT] && !port_enable;
   wire ale_on = latch_strobe ^ ale_active_low;
   sequence s_new_addr;
      req_valid && req_ready && ce ##1 ale_on;
   endsequence
   // A polarity change may flip the strobe for a cycle without an access
   sequence s_addr_phase;
      ale_on && $stable(ale_active_low) ##1 !ale_on;
   endsequence
   a_reset_idle: assert property ($fell(rst) |->
      shared_addr_data_pins_oe_n == BUS_ONES && read_strobe_n &&
      write_strobe_n && !latch_strobe && dedicated_gp_pins_oe_n == FLAG_ONES)
      else $error("pins not idle after reset");
   a_addr_value: assert property (s_new_addr |->
      shared_addr_data_pins_oe_n == BUS_ZERO && shared_addr_data_pins_out ==
      (mode_16bit ? $past(req.addr[15:0]) : $past(req.addr[23:8])))
      else $error("wrong address phase");
   a_data_after: assert property (s_addr_phase |->
      read_strobe_n != write_strobe_n)
      else $error("no data phase after address");
   a_strobe_pulse: assert property (!read_strobe_n || !write_strobe_n
      |=> read_strobe_n && write_strobe_n)
      else $error("strobe longer than one cycle");
   a_read_answer: assert property (!$past(rst, 3) |->
      rd_valid == !$past(read_strobe_n, 3))
      else $error("read data not three cycles after strobe");
   a_write_drive: assert property (!write_strobe_n |->
      shared_addr_data_pins_oe_n == BUS_ZERO)
      else $error("bus not driven in write");
   a_read_float: assert property (!read_strobe_n |->
      shared_addr_data_pins_oe_n == (mode_16bit ? BUS_ONES :
      {BUS_ZERO[15:8], BUS_ONES[7:0]}))
      else $error("data lanes driven in read");
   a_flag_quiet: assert property (gpio_mode [*2] |->
      read_strobe_n && write_strobe_n && !ale_on && !req_ready)
      else $error("bus strobes active in flag mode");
endmodule
bind mpf_port mpf_port_checker u_chk (.*);

// ===== mpf_mem_model.sv
module mpf_mem_model
   import mpf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic ale_active_low,
   input wire logic latch_strobe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic ext_en,
   input wire logic [BUS_W-1:0] ext_val,
   input wire logic [BUS_W-1:0] shared_addr_data_pins_out,
   input wire logic [BUS_W-1:0] shared_addr_data_pins_oe_n,
   output logic [BUS_W-1:0] shared_addr_data_pins_in
);
   logic [BUS_W-1:0] mem [256];
   logic [BUS_W-1:0] lat = BUS_ZERO;
   logic [2:0] hold = 3'h0;
   // Data held four cycles after the strobe, as the synchroniser needs
   wire drv = !read_strobe_n || hold != 3'h0;
   always @(posedge clk_sys) begin
      if (latch_strobe ^ ale_active_low)
         lat <= shared_addr_data_pins_out;
      if (!write_strobe_n)
         mem[lat[7:0]] <= shared_addr_data_pins_out;
      hold <= !read_strobe_n ? 3'h4 : hold - {2'b0, hold != 3'h0};
   end
   always_comb begin
      for (int i = 0; i < BUS_W; i++) begin
         if (!shared_addr_data_pins_oe_n[i])
            shared_addr_data_pins_in[i] = shared_addr_data_pins_out[i];
         else if (ext_en)
            shared_addr_data_pins_in[i] = ext_val[i];
         else
            shared_addr_data_pins_in[i] = drv ? mem[lat[7:0]][i] : 1'b1;
      end
   end
endmodule

// ===== mpf_port_test.sv
module mpf_port_test
   import mpf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Serial master and boot selects start idle
   logic ce = 1'b1, spi_master = 1'b0, spi_boot = 1'b0, boot_select_n = 1'b1;
   logic [NFLAG-1:0] spi_select_n = FLAG_ONES;
   logic clk_sys = 1'b0, rst = 1'b1, port_enable = 1'b1, mode_16bit = 1'b1;
   logic ale_active_low = 1'b0, req_valid = 1'b0, idp_capture = 1'b0;
   logic timer_expired = 1'b0, ext_en = 1'b0;
   logic [31:0] system_control_word = SC_RESET;
   mpf_req_t req = '0;
   logic [BUS_W-1:0] ext_val = BUS_ZERO, rdv;
   logic [BUS_W-1:0] bus_pins_as_gpio_out = BUS_ZERO;
   logic [BUS_W-1:0] bus_pins_as_gpio_dir = BUS_ZERO;
   logic [NFLAG-1:0] flag_out_value = FLAG_ZERO, flag_dir_out = FLAG_ZERO;
   logic [NFLAG-1:0] flag_ext = FLAG_ZERO;
   logic req_ready, rd_valid, read_strobe_n, write_strobe_n, latch_strobe;
   logic input_data_port_valid, ext_interrupt_zero, ext_interrupt_one;
   logic ext_interrupt_two;
   logic [BUS_W-1:0] rd_data, shared_addr_data_pins_in, bus_pins_as_gpio_in;
   logic [BUS_W-1:0] shared_addr_data_pins_out, shared_addr_data_pins_oe_n;
   logic [BUS_W-1:0] input_data_port_data;
   logic [NFLAG-1:0] dedicated_gp_pins_out, dedicated_gp_pins_oe_n, flag_test;
   wire [NFLAG-1:0] dedicated_gp_pins_in = (dedicated_gp_pins_out &
      ~dedicated_gp_pins_oe_n) | (flag_ext & dedicated_gp_pins_oe_n);
   int bad_count = 0, num_checks = 0, nlat = 0;
   mpf_port u_dut (.*);
   mpf_mem_model u_mem (.*);
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (!rst && (latch_strobe ^ ale_active_low)) nlat <= nlat + 1;
   task automatic cmp(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic acc(input logic wr, input logic [23:0] a,
      input logic [15:0] d);
      int n;
      n = 0;
      rdv = 'x;
      req_valid <= 1'b1;
      req <= '{wr, a, d};
      do begin
         tick(1);
         n++;
      end while (!req_ready && n < 20);
      req_valid <= 1'b0;
      repeat (6) begin
         tick(1);
         if (rd_valid) rdv = rd_data;
      end
   endtask
   task automatic t_reset;
      cmp("reset pins", {BUS_ONES, 3'b110, FLAG_ONES},
         {shared_addr_data_pins_oe_n, read_strobe_n, write_strobe_n,
         latch_strobe, dedicated_gp_pins_oe_n});
      $display("reset test done");
   endtask
   task automatic t_bus;
      int n0;
      n0 = nlat;
      acc(1'b1, 24'h00_0010, 16'h1234);
      acc(1'b1, 24'h00_0011, 16'hbeef);
      acc(1'b0, 24'h00_0010, 16'h0000);
      acc(1'b0, 24'h00_0010, 16'h0000);
      cmp("half read", 16'h1234, rdv);
      acc(1'b0, 24'h00_0011, 16'h0000);
      cmp("half read", 16'hbeef, rdv);
      cmp("half latches", 4, nlat - n0);
      mode_16bit <= 1'b0;
      ale_active_low <= 1'b1;
      tick(3);
      cmp("idle latch", 1, latch_strobe);
      n0 = nlat;
      acc(1'b1, 24'h12_3455, 16'h00ab);
      acc(1'b0, 24'h12_3455, 16'h0000);
      cmp("byte read", 8'hab, rdv[7:0]);
      acc(1'b1, 24'h12_4400, 16'h0011);
      acc(1'b0, 24'h12_4400, 16'h0000);
      cmp("byte read", 8'h11, rdv[7:0]);
      cmp("byte latches", 2, nlat - n0);
      $display("bus test done");
   endtask
   task automatic t_pins;
      int n;
      n = 0;
      system_control_word[SC_GPIO_BIT] <= 1'b1;
      port_enable <= 1'b0;
      bus_pins_as_gpio_dir <= BUS_ONES;
      bus_pins_as_gpio_out <= 16'hc3a5;
      tick(2);
      req_valid <= 1'b1;
      tick(5);
      cmp("gpio out", 16'hc3a5, shared_addr_data_pins_out);
      cmp("gpio oe_n", BUS_ZERO, shared_addr_data_pins_oe_n);
      cmp("bus ctl", 4'b1110, {read_strobe_n, write_strobe_n,
         latch_strobe, req_ready});
      req_valid <= 1'b0;
      bus_pins_as_gpio_dir <= BUS_ZERO;
      ext_en <= 1'b1;
      ext_val <= 16'h1e2d;
      tick(5);
      cmp("gpio in", 16'h1e2d, bus_pins_as_gpio_in);
      idp_capture <= 1'b1;
      tick(1);
      idp_capture <= 1'b0;
      while (!input_data_port_valid && n < 8) begin
         tick(1);
         n++;
      end
      cmp("idp", {1'b1, 16'h1e2d}, {input_data_port_valid,
         input_data_port_data});
      ext_en <= 1'b0;
      system_control_word[SC_GPIO_BIT] <= 1'b0;
      port_enable <= 1'b1;
      $display("pin test done");
   endtask
   task automatic t_flags;
      flag_dir_out <= 4'h5;
      flag_out_value <= 4'h1;
      flag_ext <= 4'ha;
      tick(5);
      cmp("flag oe_n", 4'ha, dedicated_gp_pins_oe_n);
      cmp("flag test", 4'hb, flag_test);
      flag_dir_out <= FLAG_ZERO;
      flag_ext <= 4'h8;
      system_control_word[SC_EXT_INTERRUPT_TWO_BIT:SC_EXT_INTERRUPT_ZERO_BIT] <= 3'b011;
      tick(5);
      cmp("irq", 3'b011, {ext_interrupt_two, ext_interrupt_one,
         ext_interrupt_zero});
      system_control_word[SC_TMX_BIT] <= 1'b1;
      timer_expired <= 1'b1;
      tick(5);
      cmp("timer pin", 2'b10, {dedicated_gp_pins_out[3],
         dedicated_gp_pins_oe_n[3]});
      $display("flag test done");
   endtask
   task automatic t_spi;
      system_control_word <= SC_RESET;
      spi_master <= 1'b1;
      spi_select_n <= 4'hd;
      tick(3);
      cmp("spi selects", {4'hd, FLAG_ZERO},
         {dedicated_gp_pins_out, dedicated_gp_pins_oe_n});
      spi_boot <= 1'b1;
      boot_select_n <= 1'b0;
      tick(3);
      cmp("boot select", 4'hc, dedicated_gp_pins_out);
      ce <= 1'b0;
      spi_select_n <= 4'h2;
      tick(3);
      cmp("frozen flags", 4'hc, dedicated_gp_pins_out);
      ce <= 1'b1;
      tick(3);
      cmp("resumed flags", 4'h2, dedicated_gp_pins_out);
      $display("spi test done");
   endtask
   task automatic end_sim;
      $display("%0d checks, %0d mismatches", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Whole run is about 110 cycles; this only cuts a hang
   initial begin
      tick(2000);
      bad_count++;
      end_sim;
   end
   initial begin
      tick(3);
      rst <= 1'b0;
      tick(1);
      t_reset;
      t_bus;
      t_pins;
      t_flags;
      t_spi;
      end_sim;
   end
endmodule
